// *** hw/pdl_pkg.sv ***
`default_nettype none

package pdl_pkg;

	// System clock
	localparam int unsigned CLK_HZ            = 20_000_000;
	localparam int unsigned CLK_MHZ           = 20;

	// Outage limit: a shorter outage steps the level down
	localparam int unsigned OUTAGE_LIMIT_MS   = 1000;
	localparam int unsigned OUTAGE_CYCLES     = (CLK_HZ / 1000) * OUTAGE_LIMIT_MS;

	// Line-sense glitch filter, kept very short
	localparam int unsigned FILTER_TIME_NS    = 1000;
	localparam int unsigned FILTER_CYCLES     = (FILTER_TIME_NS * CLK_MHZ + 999) / 1000;

	// Fixed PWM frequency
	localparam int unsigned PWM_FREQ_HZ       = 20_000;
	localparam int unsigned PWM_PERIOD_CYCLES = CLK_HZ / PWM_FREQ_HZ;
	localparam int unsigned PWM_CNT_W         = 10;

	// Level encoding: 3 is brightest, 0 is dimmest
	localparam int unsigned LVL_W             = 2;
	typedef logic [LVL_W-1:0] pdl_level_t;
	localparam pdl_level_t  LVL_MAX           = 2'h3;
	localparam pdl_level_t  LVL_MIN           = 2'h0;
	localparam pdl_level_t  LVL_RESET         = LVL_MAX;

	// High time per level, in clock cycles out of the period
	localparam logic [3:0][PWM_CNT_W-1:0] DUTY_TBL = {
		10'h36b,
		10'h271,
		10'h177,
		10'h07d
	};

	// Non-volatile storage ports
	typedef struct packed {
		logic       valid;
		pdl_level_t level;
	} pdl_nv_rd_s;

	typedef struct packed {
		logic       stb;
		pdl_level_t level;
	} pdl_nv_wr_s;

	typedef enum logic [3:0] {
		ST_LOAD = 4'h1,
		ST_RUN  = 4'h2,
		ST_OUT  = 4'h4,
		ST_HOLD = 4'h8
	} pdl_state_e;

endpackage

`default_nettype wire

// *** hw/pdl_pwm.sv ***
`timescale 1ns/1ps
`default_nettype none

module pdl_pwm #(
	parameter int unsigned PERIOD = pdl_pkg::PWM_PERIOD_CYCLES,
	parameter int unsigned CNT_W  = pdl_pkg::PWM_CNT_W
) (
	input  wire logic              clk,
	input  wire logic              arst_n,
	input  wire logic              run,
	input  wire pdl_pkg::pdl_level_t level,
	output logic                   pwm_out
);
	import pdl_pkg::*;

	localparam logic [CNT_W-1:0] LAST = CNT_W'(PERIOD - 1);

	logic [CNT_W-1:0] cnt_ff;
	logic [CNT_W-1:0] nxt_cnt;
	logic [CNT_W-1:0] duty_ff;
	logic [CNT_W-1:0] nxt_duty;
	logic             out_ff;
	logic             nxt_out;

	// Fixed period; new duty only at a period boundary to avoid runt pulses
	always_comb begin
		nxt_cnt  = cnt_ff;
		nxt_duty = duty_ff;
		nxt_out  = 1'b0;
		if (!run) begin
			// Park on the last count so the first period is full length
			nxt_cnt  = LAST; // RQ1
			nxt_duty = DUTY_TBL[level];
		end else begin
			if (cnt_ff == LAST) begin // RQ1
				nxt_cnt  = '0;
				nxt_duty = DUTY_TBL[level]; // RQ2
			end else begin
				nxt_cnt = cnt_ff + 1'b1;
			end
			nxt_out = (nxt_cnt < nxt_duty); // RQ1
		end
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			cnt_ff  <= '0;
			duty_ff <= '0;
			out_ff  <= 1'b0;
		end else begin
			cnt_ff  <= nxt_cnt;
			duty_ff <= nxt_duty;
			out_ff  <= nxt_out;
		end
	end

	assign pwm_out = out_ff;

endmodule

`default_nettype wire

// *** hw/pdl_level_controller.sv ***
`timescale 1ns/1ps
`default_nettype none

// Contract
// RQ1: Output a fixed-frequency square wave with one of four duty cycles.
// RQ2: Brighter levels use larger duty cycles, giving higher filtered voltage.
// RQ3: Detect mains loss and return on line sense with very little delay.
// RQ4: Start an elapsed-time counter at the moment mains loss is seen.
// RQ5: Mains back before one second steps the level one lower.
// RQ6: Stepping down from the lowest level selects the highest level.
// RQ7: Outage longer than one second leaves the level unchanged.
// RQ8: Store level in non-volatile memory before supply fails; resume it at start.
// RQ9: Level is two bits; invalid stored value starts at highest level.
// RQ10: One-second limit counts clock cycles, set by a parameter.
module pdl_level_controller #(
	parameter int unsigned OUTAGE_CYCLES = pdl_pkg::OUTAGE_CYCLES,
	parameter int unsigned FILTER_CYCLES = pdl_pkg::FILTER_CYCLES,
	parameter int unsigned PWM_PERIOD    = pdl_pkg::PWM_PERIOD_CYCLES
) (
	input  wire logic                clk,
	input  wire logic                arst_n,
	input  wire logic                line_sense_input,
	input  wire pdl_pkg::pdl_nv_rd_s nv_rd,
	output pdl_pkg::pdl_nv_wr_s      nv_wr,
	output logic                     dim_square_wave_output,
	output pdl_pkg::pdl_level_t      level,
	output logic                     mains_ok,
	output logic                     outage_active
);
	import pdl_pkg::*;

	localparam int unsigned OUT_CNT_W = $clog2(OUTAGE_CYCLES + 1);
	localparam int unsigned FLT_CNT_W = $clog2(FILTER_CYCLES + 1);
	localparam logic [OUT_CNT_W-1:0] OUT_LIMIT = OUT_CNT_W'(OUTAGE_CYCLES);
	localparam logic [FLT_CNT_W-1:0] FLT_LAST  = FLT_CNT_W'(FILTER_CYCLES - 1);

	// Line-sense synchroniser
	logic sync1_ff;
	logic sync2_ff;

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			sync1_ff <= 1'b0;
			sync2_ff <= 1'b0;
		end else begin
			sync1_ff <= line_sense_input;
			sync2_ff <= sync1_ff;
		end
	end

	// Short glitch filter and edge pulses
	logic [FLT_CNT_W-1:0] flt_cnt_ff;
	logic [FLT_CNT_W-1:0] nxt_flt_cnt;
	logic                 mains_ok_ff;
	logic                 nxt_mains_ok;
	logic                 loss_ff;
	logic                 nxt_loss;
	logic                 back_ff;
	logic                 nxt_back;

	always_comb begin
		nxt_flt_cnt  = '0;
		nxt_mains_ok = mains_ok_ff;
		nxt_loss     = 1'b0;
		nxt_back     = 1'b0;
		if (sync2_ff != mains_ok_ff) begin
			if (flt_cnt_ff >= FLT_LAST) begin // RQ3
				nxt_mains_ok = sync2_ff;
				nxt_loss     = mains_ok_ff;
				nxt_back     = sync2_ff;
			end else begin
				nxt_flt_cnt = flt_cnt_ff + 1'b1;
			end
		end
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			flt_cnt_ff  <= '0;
			mains_ok_ff <= 1'b0;
			loss_ff     <= 1'b0;
			back_ff     <= 1'b0;
		end else begin
			flt_cnt_ff  <= nxt_flt_cnt;
			mains_ok_ff <= nxt_mains_ok;
			loss_ff     <= nxt_loss;
			back_ff     <= nxt_back;
		end
	end

	// Level state machine
	pdl_state_e           state_ff;
	pdl_state_e           nxt_state;
	pdl_level_t           level_ff;
	pdl_level_t           nxt_level;
	logic [OUT_CNT_W-1:0] out_cnt_ff;
	logic [OUT_CNT_W-1:0] nxt_out_cnt;
	pdl_nv_wr_s           nv_wr_ff;
	pdl_nv_wr_s           nxt_nv_wr;
	logic                 run_ff;
	logic                 nxt_run;
	logic                 outage_ff;
	logic                 nxt_outage;

	always_comb begin
		nxt_state   = state_ff;
		nxt_level   = level_ff;
		nxt_out_cnt = out_cnt_ff;
		nxt_nv_wr   = '{stb: 1'b0, level: nv_wr_ff.level};
		nxt_run     = run_ff;
		nxt_outage  = 1'b0;
		case (state_ff)
			ST_LOAD: begin
				// Resume the stored level, or brightest if none is valid
				if (nv_rd.valid) begin
					nxt_level = nv_rd.level; // RQ8
				end else begin
					nxt_level = LVL_RESET; // RQ9
				end
				nxt_run   = 1'b1;
				nxt_state = ST_RUN;
			end
			ST_RUN: begin
				if (loss_ff) begin
					nxt_out_cnt = '0; // RQ4
					// Save while the hold-up capacitor still carries us
					nxt_nv_wr  = '{stb: 1'b1, level: level_ff}; // RQ8
					nxt_outage = 1'b1;
					nxt_state  = ST_OUT;
				end
			end
			ST_OUT: begin
				nxt_outage = 1'b1;
				if (back_ff && (out_cnt_ff < OUT_LIMIT)) begin // RQ5
					if (level_ff == LVL_MIN) begin
						nxt_level = LVL_MAX; // RQ6
					end else begin
						nxt_level = level_ff - 1'b1; // RQ5
					end
					nxt_nv_wr  = '{stb: 1'b1, level: nxt_level}; // RQ8
					nxt_outage = 1'b0;
					nxt_state  = ST_RUN;
				end else if (back_ff) begin
					// Return right on the limit counts as a long outage
					nxt_outage = 1'b0;
					nxt_state  = ST_RUN; // RQ7
				end else if (out_cnt_ff >= OUT_LIMIT) begin // RQ10
					nxt_state = ST_HOLD; // RQ7
				end else begin
					nxt_out_cnt = out_cnt_ff + 1'b1; // RQ4
				end
			end
			ST_HOLD: begin
				nxt_outage = 1'b1;
				if (back_ff) begin
					nxt_outage = 1'b0;
					nxt_state  = ST_RUN; // RQ7
				end
			end
			default: begin
				nxt_state = ST_LOAD;
				nxt_run   = 1'b0;
			end
		endcase
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			state_ff   <= ST_LOAD;
			level_ff   <= LVL_RESET;
			out_cnt_ff <= '0;
			nv_wr_ff   <= '{stb: 1'b0, level: LVL_RESET};
			run_ff     <= 1'b0;
			outage_ff  <= 1'b0;
		end else begin
			state_ff   <= nxt_state;
			level_ff   <= nxt_level;
			out_cnt_ff <= nxt_out_cnt;
			nv_wr_ff   <= nxt_nv_wr;
			run_ff     <= nxt_run;
			outage_ff  <= nxt_outage;
		end
	end

	pdl_pwm #(
		.PERIOD (PWM_PERIOD),
		.CNT_W  (PWM_CNT_W)
	) u_pwm ( // RQ1 RQ2
		.clk     (clk),
		.arst_n  (arst_n),
		.run     (run_ff),
		.level   (level_ff),
		.pwm_out (dim_square_wave_output)
	);

	assign nv_wr         = nv_wr_ff;
	assign level         = level_ff;
	assign mains_ok      = mains_ok_ff;
	assign outage_active = outage_ff;

endmodule

`default_nettype wire

// *** dv/pdl_props.sv ***
`timescale 1ns/1ps
`default_nettype none
module pdl_props #(parameter int unsigned PWM_PERIOD = 1000) (
	input wire logic                clk,
	input wire logic                arst_n,
	input wire logic                line_sense_input,
	input wire pdl_pkg::pdl_nv_wr_s nv_wr,
	input wire logic                dim_square_wave_output,
	input wire pdl_pkg::pdl_level_t level,
	input wire logic                mains_ok,
	input wire logic                outage_active
);
	import pdl_pkg::*;
	int   per_ff, nxt_per;
	logic prev_ff, seen_ff, nxt_seen, rise;
	default clocking @(posedge clk); endclocking
	default disable iff (!arst_n);
	always_comb begin
		rise = dim_square_wave_output && !prev_ff;
		nxt_per = rise ? 0 : per_ff + 1;
		nxt_seen = seen_ff || rise;
	end
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			per_ff <= 0;
			prev_ff <= 1'b0;
			seen_ff <= 1'b0;
		end else begin
			per_ff <= nxt_per;
			prev_ff <= dim_square_wave_output;
			seen_ff <= nxt_seen;
		end
	end
	period_fix_a: assert property (rise && seen_ff |-> per_ff == PWM_PERIOD - 1)
		else $error("pwm period");
	loss_seen_a: assert property ($fell(line_sense_input) ##1 !line_sense_input [*8] |-> !mains_ok)
		else $error("loss missed");
	back_seen_a: assert property ($rose(line_sense_input) ##1 line_sense_input [*8] |-> mains_ok)
		else $error("return missed");
	out_start_a: assert property ($rose(outage_active) |-> !mains_ok && nv_wr.stb && nv_wr.level == level)
		else $error("outage start");
	lvl_step_a: assert property ($past(outage_active) && level != $past(level)
		|-> level == $past(level) - 2'h1 && nv_wr.stb && nv_wr.level == level && !outage_active)
		else $error("bad step");
	lvl_hold_a: assert property (!$past(outage_active) && $past(arst_n, 2) |-> $stable(level))
		else $error("level moved");
	stb_pulse_a: assert property (nv_wr.stb |=> !nv_wr.stb)
		else $error("strobe long");
	stb_cause_a: assert property (nv_wr.stb |-> outage_active || $past(outage_active))
		else $error("stray write");
endmodule
`default_nettype wire

// *** dv/pdl_rc_filter.sv ***
`timescale 1ns/1ps
`default_nettype none
// Boxcar over one period stands in for the RC filter
module pdl_rc_filter #(parameter int unsigned N = 1000) (
	input wire logic    clk,
	input wire logic    pwm,
	output logic [15:0] vout
);
	logic [N-1:0] win_ff = '0;
	logic [15:0]  sum_ff = '0;
	assign vout = sum_ff;
	always_ff @(posedge clk) begin
		win_ff <= {win_ff[N-2:0], pwm};
		sum_ff <= sum_ff + 16'(pwm) - 16'(win_ff[N-1]);
	end
endmodule
`default_nettype wire

// *** dv/testbench.sv ***
`timescale 1ns/1ps
`default_nettype none
module testbench;
	import pdl_pkg::*;
	localparam int unsigned LIM = 200;
	localparam int unsigned PER = 1000;
	logic        clk, arst_n, line, pwm, mains_ok, outage_active;
	pdl_nv_rd_s  nv_rd;
	pdl_nv_wr_s  nv_wr;
	pdl_level_t  level, cur;
	pdl_level_t  exp_q[$];
	logic [15:0] vout;
	logic [31:0] seed;
	int          bad_count, n_tests, cyc;

	pdl_level_controller #(.OUTAGE_CYCLES(LIM), .FILTER_CYCLES(3), .PWM_PERIOD(PER))
	pdl_level_controller_i (.clk(clk), .arst_n(arst_n), .line_sense_input(line),
		.nv_rd(nv_rd), .nv_wr(nv_wr), .dim_square_wave_output(pwm), .level(level),
		.mains_ok(mains_ok), .outage_active(outage_active));
	pdl_rc_filter #(.N(PER)) pdl_rc_filter_i (.clk(clk), .pwm(pwm), .vout(vout));

	function automatic logic [31:0] xs(input logic [31:0] s);
		s ^= s << 13;
		s ^= s >> 17;
		s ^= s << 5;
		return s;
	endfunction

	task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
		n_tests++;
		if (seen !== exp) begin
			bad_count++;
			$display("unexpected %s exp %h seen %h", what, exp, seen);
		end
	endtask

	task automatic summarize();
		$display("checks %0d mismatches %0d", n_tests, bad_count);
		if (bad_count == 0 && n_tests > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask

	task automatic do_reset(input logic v, input pdl_level_t l);
		@(posedge clk);
		arst_n <= 1'b0;
		nv_rd <= '{valid: v, level: l};
		repeat (4) @(posedge clk);
		arst_n <= 1'b1;
		repeat (40) @(posedge clk);
	endtask

	// Loss writes the old level; a short outage then writes the new one
	task automatic outage(input int d);
		@(posedge clk);
		line <= 1'b0;
		exp_q.push_back(cur);
		if (d < LIM) begin
			cur = cur - 2'h1;
			exp_q.push_back(cur);
		end
		repeat (d) @(posedge clk);
		line <= 1'b1;
		repeat (40) @(posedge clk);
		chk("level", level, cur);
	endtask

	task automatic duty();
		repeat (2 * PER + 100) @(posedge clk);
		chk("vout", vout, DUTY_TBL[cur]);
	endtask

	initial begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end

	always @(posedge clk) begin
		cyc++;
		if (arst_n === 1'b1 && nv_wr.stb === 1'b1)
			chk("nv_wr", nv_wr.level, exp_q.size() > 0 ? exp_q.pop_front() : 2'bxx);
		if (cyc == 40000) begin
			bad_count++;
			summarize();
		end
	end

	initial begin
		arst_n = 1'b0;
		line = 1'b1;
		nv_rd = '0;
		seed = 32'hb510;
		cur = 2'h1;
		do_reset(1'b1, 2'h1);
		chk("level", level, cur);
		duty();
		$display("test resume done");
		for (int i = 0; i < 4; i++) begin
			seed = xs(seed);
			outage(40 + int'(seed % 100));
			duty();
		end
		$display("test short done");
		seed = xs(seed);
		outage(300 + int'(seed % 50));
		$display("test long done");
		cur = LVL_MAX;
		do_reset(1'b0, 2'h1);
		chk("level", level, cur);
		chk("queue", 16'(exp_q.size()), 16'h0);
		$display("test blank done");
		summarize();
	end
endmodule

bind pdl_level_controller pdl_props #(.PWM_PERIOD(PWM_PERIOD)) pdl_props_i (
	.clk(clk), .arst_n(arst_n), .line_sense_input(line_sense_input), .nv_wr(nv_wr),
	.dim_square_wave_output(dim_square_wave_output), .level(level),
	.mains_ok(mains_ok), .outage_active(outage_active));
`default_nettype wire
